/* File: pkg/psq_pkg.sv */
// constants and carrier types for the pseudo-static ram host sequencer
package psq_pkg;
  localparam int CLK_MHZ = 250;
  localparam int PU_PD_LOW_US = 50;
  localparam int PU_SEL_HIGH_US = 300;
  localparam int PAGE_MAX_US = 4;
  localparam int SETTLE_NS = 10;
  localparam int RC_NS = 65;
  localparam int WP_NS = 40;
  localparam int CP_NS = 12;
  localparam int C2LP_NS = 65;
  localparam int PU_PD_LOW_CYC = PU_PD_LOW_US * CLK_MHZ;
  localparam int PU_SEL_HIGH_CYC = PU_SEL_HIGH_US * CLK_MHZ;
  localparam int PAGE_MAX_CYC = PAGE_MAX_US * CLK_MHZ;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RC_CYC = (RC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
  localparam int CP_CYC = (CP_NS * CLK_MHZ + 999) / 1000;
  localparam int C2LP_CYC = (C2LP_NS * CLK_MHZ + 999) / 1000;
  localparam int PGM_CYCLES = 6;
  localparam int PGM_ADDR_HIGH_LAST = 5;
  localparam int CW = 20;
  localparam int AW = 21;
  localparam int DW = 16;

  typedef enum logic [3:0] {
    ST_PU_LOW = 4'h0,
    ST_PU_HOLD = 4'h1,
    ST_IDLE = 4'h2,
    ST_RD = 4'h3,
    ST_WR = 4'h4,
    ST_SETTLE = 4'h5,
    ST_PRE = 4'h6,
    ST_PD_LOW = 4'h7,
    ST_PD_HOLD = 4'h8
  } psq_state_t;

  typedef struct packed {
    logic cs_n;
    logic pd_en;
    logic we_n;
    logic oe_n;
    logic lb_n;
    logic ub_n;
    logic dq_oe;
  } psq_pins_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic pgm;
    logic pdown;
    logic [1:0] be_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } psq_req_t;

  typedef struct packed {
    psq_state_t st;
    psq_pins_t pin;
    logic [AW-1:0] addr;
    logic [DW-1:0] dout;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic done;
    logic ready;
    logic is_wr;
    logic pgm;
    logic [2:0] pgm_n;
    logic [CW-1:0] cnt;
    logic [DW-1:0] rq_s1;
    logic [DW-1:0] rq_s2;
  } psq_state_all_t;
endpackage

/* File: hdl/psq_host.sv */
// host sequencer driving the pseudo-static ram die pins
`timescale 1ns/10ps
module psq_host
  import psq_pkg::*;
#(
  parameter int PU_LOW_CYCLES = PU_PD_LOW_CYC,
  parameter int PU_HOLD_CYCLES = PU_SEL_HIGH_CYC
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire psq_req_t req_in,
  input wire logic [DW-1:0] dq_in,
  output logic ready_out,
  output logic done_out,
  output logic rvalid_out,
  output logic [DW-1:0] rdata_out,
  output psq_pins_t pins_out,
  output logic [AW-1:0] addr_out,
  output logic [DW-1:0] dq_out
);
  // =========================================================
  // parameter checks
  if (PU_LOW_CYCLES < 1 || PU_LOW_CYCLES >= (1 << CW)) begin
    $error("PU_LOW_CYCLES out of range");
  end
  if (PU_HOLD_CYCLES < 1 || PU_HOLD_CYCLES >= (1 << CW)) begin
    $error("PU_HOLD_CYCLES out of range");
  end
  if (RC_CYC < 1 || WP_CYC < 1 || CP_CYC < 1 || SETTLE_CYC < 1) begin
    $error("strobe timing counts must be at least one");
  end
  if (PGM_CYCLES > 7 || PGM_ADDR_HIGH_LAST >= PGM_CYCLES) begin
    $error("program sequence counts out of range");
  end
  if (C2LP_CYC < 1 || C2LP_CYC >= (1 << CW)) begin
    $error("power-down low count out of range");
  end
  if (PAGE_MAX_CYC < RC_CYC + 1) begin
    $error("read cycle longer than select low limit");
  end

  // =========================================================
  // constants
  localparam logic [CW-1:0] ONE = 20'h00001;
  localparam logic [CW-1:0] C_PUL = CW'(PU_LOW_CYCLES);
  localparam logic [CW-1:0] C_PUH = CW'(PU_HOLD_CYCLES);
  localparam logic [CW-1:0] C_RC = CW'(RC_CYC);
  localparam logic [CW-1:0] C_WP = CW'(WP_CYC);
  localparam logic [CW-1:0] C_CP = CW'(CP_CYC);
  localparam logic [CW-1:0] C_ST = CW'(SETTLE_CYC);
  localparam logic [CW-1:0] C_C2 = CW'(C2LP_CYC);
  localparam logic [2:0] N_PGM = 3'(PGM_CYCLES);
  localparam logic [2:0] N_AH = 3'(PGM_ADDR_HIGH_LAST);
  localparam psq_pins_t PIN_RST = '{cs_n: 1'b1, pd_en: 1'b0, we_n: 1'b1,
    oe_n: 1'b1, lb_n: 1'b1, ub_n: 1'b1, dq_oe: 1'b0};

  // =========================================================
  // state
  psq_state_all_t s_q;
  psq_state_all_t s_d;

  // =========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.rq_s1 = dq_in;
    s_d.rq_s2 = s_q.rq_s1;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - ONE;
    end
    unique case (s_q.st)
      ST_PU_LOW: begin
        s_d.pin = PIN_RST;
        if (s_q.cnt == '0) begin
          s_d.pin.pd_en = 1'b1;
          s_d.cnt = C_PUH;
          s_d.st = ST_PU_HOLD;
        end
      end
      ST_PU_HOLD: begin
        if (s_q.cnt == '0) begin
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (req_in.pdown) begin
          s_d.ready = 1'b0;
          s_d.pin.pd_en = 1'b0;
          s_d.cnt = C_C2;
          s_d.st = ST_PD_LOW;
        end else if (req_in.pgm || req_in.rd || req_in.wr) begin
          s_d.ready = 1'b0;
          s_d.pgm = req_in.pgm;
          s_d.pgm_n = '0;
          s_d.is_wr = req_in.wr && !req_in.rd && !req_in.pgm;
          s_d.addr = req_in.pgm ? '1 : req_in.addr;
          s_d.dout = req_in.wdata;
          s_d.cnt = C_CP;
          s_d.st = ST_PRE;
        end
      end
      ST_PRE: begin
        if (s_q.cnt == '0) begin
          s_d.pin.pd_en = 1'b1;
          s_d.pin.cs_n = 1'b0;
          s_d.cnt = s_q.is_wr ? C_WP : C_RC;
          if (s_q.is_wr) begin
            s_d.pin.oe_n = 1'b1;
            s_d.pin.we_n = 1'b0;
            s_d.pin.dq_oe = 1'b1;
            {s_d.pin.ub_n, s_d.pin.lb_n} = req_be(s_q);
            s_d.st = ST_WR;
          end else begin
            s_d.pin.we_n = 1'b1;
            s_d.pin.oe_n = 1'b0;
            {s_d.pin.ub_n, s_d.pin.lb_n} = s_q.pgm ? 2'h0 : req_be(s_q);
            s_d.st = ST_RD;
          end
        end
      end
      ST_RD, ST_WR: begin
        if (s_q.cnt == '0) begin
          if (s_q.st == ST_RD) begin
            s_d.rdata = s_q.rq_s2;
            s_d.rvalid = !s_q.pgm;
          end
          s_d.pin.cs_n = 1'b1;
          s_d.cnt = C_ST;
          s_d.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (s_q.cnt == '0) begin
          s_d.pin.we_n = 1'b1;
          s_d.pin.oe_n = 1'b1;
          s_d.pin.dq_oe = 1'b0;
          s_d.pin.lb_n = 1'b1;
          s_d.pin.ub_n = 1'b1;
          if (s_q.pgm && s_q.pgm_n < N_PGM - 3'h1) begin
            s_d.pgm_n = s_q.pgm_n + 3'h1;
            s_d.is_wr = (s_q.pgm_n + 3'h1) == N_PGM - 3'h1;
            s_d.addr = ((s_q.pgm_n + 3'h1) < N_AH) ? '1 : s_q.addr;
            s_d.cnt = C_CP;
            s_d.st = ST_PRE;
          end else begin
            s_d.cnt = C_CP;
            s_d.st = ST_PD_HOLD;
          end
        end
      end
      ST_PD_LOW: begin
        if (s_q.cnt == '0) begin
          s_d.pin.pd_en = 1'b1;
          s_d.cnt = C_RC;
          s_d.st = ST_PD_HOLD;
        end
      end
      ST_PD_HOLD: begin
        if (s_q.cnt == '0) begin
          s_d.pgm = 1'b0;
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_PU_LOW;
      end
    endcase
  end

  // =========================================================
  // byte lanes
  function automatic logic [1:0] req_be(input psq_state_all_t s);
    req_be = (s.pgm ? 2'h0 : req_in.be_n);
    if (req_be == 2'h3) begin
      req_be = 2'h0;
    end
  endfunction

  // =========================================================
  // state register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.st <= ST_PU_LOW;
      s_q.pin <= PIN_RST;
      s_q.cnt <= C_PUL;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // outputs
  assign ready_out = s_q.ready;
  assign done_out = s_q.done;
  assign rvalid_out = s_q.rvalid;
  assign rdata_out = s_q.rdata;
  assign pins_out = s_q.pin;
  assign addr_out = s_q.addr;
  assign dq_out = s_q.dout;
endmodule

/* File: verification/psq_host_monitor.sv */
// property checker for the host sequencer pins
`timescale 1ns/10ps
module psq_host_monitor
  import psq_pkg::*;
#(
  parameter int PU_LOW_CYCLES = PU_PD_LOW_CYC,
  parameter int PU_HOLD_CYCLES = PU_SEL_HIGH_CYC
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire psq_req_t req_in,
  input wire logic ready_out,
  input wire logic done_out,
  input wire psq_pins_t pins_out,
  input wire logic [AW-1:0] addr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire rd_on = !pins_out.cs_n && !pins_out.oe_n;
  wire pgm_go = ready_out && clk_en_in && req_in.pgm && !req_in.pdown;
  // ==========================================
  // pin sequencing
  a_rd_ctrl_high: assert property (rd_on |-> pins_out.pd_en && pins_out.we_n)
    else $error("read strobe without power-down and write high");
  a_rd_lane_low: assert property (rd_on |-> !(pins_out.lb_n && pins_out.ub_n))
    else $error("read strobe with no byte lane");
  a_wr_pd_high: assert property (!pins_out.we_n |-> pins_out.pd_en)
    else $error("write strobe while powered down");
  a_pgm_addr_ones: assert property (pgm_go |=> (pins_out.cs_n || &addr_out) until done_out)
    else $error("program access address not all ones");
  a_pgm_done_bound: assert property (pgm_go |-> ##[1:400] done_out)
    else $error("program sequence did not finish");
  a_pu_pd_low: assert property ($rose(pins_out.pd_en) |-> !$past(pins_out.pd_en, PU_LOW_CYCLES))
    else $error("power-down low too short");
  a_pu_sel_hold: assert property ($rose(pins_out.pd_en) |-> pins_out.cs_n[*8])
    else $error("select low too soon after power-down rise");
  a_strobe_settle: assert property ($rose(pins_out.cs_n) |-> ##1 $stable({pins_out.oe_n, pins_out.we_n})[*2])
    else $error("strobes moved too soon after select rise");
  a_page_close: assert property ($fell(pins_out.cs_n) |-> ##[1:1000] pins_out.cs_n)
    else $error("select held low too long");
  c_pgm: cover property (pgm_go);
  c_pd_exit: cover property ($rose(pins_out.pd_en));
  c_lane_rd: cover property (rd_on && !pins_out.lb_n && pins_out.ub_n);
endmodule
bind psq_host psq_host_monitor #(.PU_LOW_CYCLES(PU_LOW_CYCLES),
  .PU_HOLD_CYCLES(PU_HOLD_CYCLES)) u_mon (.clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in), .clk_en_in(clk_en_in), .req_in(req_in),
  .ready_out(ready_out), .done_out(done_out), .pins_out(pins_out),
  .addr_out(addr_out));

/* File: verification/psq_ram_model.sv */
// behavioural pseudo-static ram die
`timescale 1ns/10ps
module psq_ram_model
  import psq_pkg::*;
(
  input wire psq_pins_t pins_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out
);
  logic [DW-1:0] mem [int];
  logic [AW-1:0] wa;
  logic [DW-1:0] m, wm, wd, v;
  logic wact = 1'b0;
  initial dq_out = 16'h0000;
  always @(pins_in or addr_in or dq_in) begin
    m = {{8{~pins_in.ub_n}}, {8{~pins_in.lb_n}}};
    if (!pins_in.pd_en) begin
      wact = 1'b0;
    end else if (!pins_in.cs_n && !pins_in.we_n) begin
      if (!wact) wa = addr_in;
      wact = 1'b1;
      wd = dq_in;
      wm = m;
    end else if (wact) begin
      v = mem.exists(wa) ? mem[wa] : 16'h0000;
      mem[wa] = (v & ~wm) | (wd & wm);
      wact = 1'b0;
    end
    if (pins_in.pd_en && !pins_in.cs_n && !pins_in.oe_n && pins_in.we_n) begin
      v = mem.exists(addr_in) ? mem[addr_in] : 16'h0000;
      dq_out = (v & m) | (~dq_out & ~m);
    end else begin
      dq_out = ~dq_out;
    end
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the host sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import psq_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic en = 1'b1;
  psq_req_t req;
  psq_pins_t pins;
  logic ready, done, rvalid, got_rv, got_dn;
  logic [AW-1:0] addr, a;
  logic [DW-1:0] dq_in, dq_out, rdata, got_d, d, e, m;
  logic [DW-1:0] ref_m [int];
  logic [1:0] be;
  logic [3:0] k;
  int mismatches = 0, n_checks = 0, seed = 8, cyc = 0, c0;
  always #2 clk_sys_in = ~clk_sys_in;
  psq_host #(.PU_LOW_CYCLES(4), .PU_HOLD_CYCLES(8)) DUT (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(en),
    .req_in(req), .dq_in(dq_in), .ready_out(ready), .done_out(done),
    .rvalid_out(rvalid), .rdata_out(rdata), .pins_out(pins),
    .addr_out(addr), .dq_out(dq_out));
  psq_ram_model u_ram (.pins_in(pins), .addr_in(addr), .dq_in(dq_out),
    .dq_out(dq_in));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task wait_ready;
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 500) begin
      @(posedge clk_sys_in); #1;
      t++;
    end
    if (t >= 500) mismatches++;
  endtask
  task op(input logic [3:0] kk, input logic [1:0] b, input logic [AW-1:0] aa,
          input logic [DW-1:0] dd);
    int t;
    wait_ready();
    req = '{rd:kk[3], wr:kk[2], pgm:kk[1], pdown:kk[0], be_n:b, addr:aa, wdata:dd};
    got_rv = 1'b0;
    got_dn = 1'b0;
    t = 0;
    do begin
      @(posedge clk_sys_in); #1;
      t++;
      if (rvalid === 1'b1) begin got_rv = 1'b1; got_d = rdata; end
      if (done === 1'b1) got_dn = 1'b1;
    end while (ready !== 1'b1 && t < 500);
    if (t >= 500) mismatches++;
    req = '0;
    @(posedge clk_sys_in); #1;
  endtask
  function automatic logic [DW-1:0] lanes(input logic [1:0] b);
    if (b == 2'h3) return 16'hFFFF;
    return {{8{~b[1]}}, {8{~b[0]}}};
  endfunction
  task rd_chk(input logic [1:0] b, input logic [AW-1:0] aa);
    op(4'h8, b, aa, 16'h0000);
    m = lanes(b);
    e = ref_m.exists(aa) ? ref_m[aa] : 16'h0000;
    `CHK("rvalid", 1'b1, got_rv)
    `CHK("rdata", e & m, got_d & m)
  endtask
  initial begin
    req = '0;
    repeat (10) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    for (int i = 0; i < 24; i++) begin
      k = $random(seed) & 1 ? 4'h8 : 4'h4;
      be = 2'($random(seed));
      a = (i % 7 == 6) ? '1 : AW'($random(seed) & 7);
      d = 16'($random(seed));
      if (k[3]) rd_chk(be, a);
      else begin
        op(k, be, a, d);
        e = ref_m.exists(a) ? ref_m[a] : 16'h0000;
        ref_m[a] = (e & ~lanes(be)) | (d & lanes(be));
      end
    end
    op(4'h2, 2'h0, '0, 16'hA5C3);
    `CHK("pgm_done", 1'b1, got_dn)
    ref_m[{AW{1'b1}}] = 16'hA5C3;
    rd_chk(2'h0, '1);
    op(4'h9, 2'h0, 21'h000003, 16'h0000);
    `CHK("pd_done", 1'b1, got_dn)
    `CHK("pd_no_read", 1'b0, got_rv)
    op(4'h4, 2'h1, 21'h000003, 16'h5A3C);
    e = ref_m.exists(3) ? ref_m[3] : 16'h0000;
    ref_m[3] = {8'h5A, e[7:0]};
    rd_chk(2'h0, 21'h000003);
    en = 1'b0;
    nrst_in = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    c0 = cyc;
    repeat (20) @(posedge clk_sys_in);
    #1;
    `CHK("ready_low", 1'b0, ready)
    `CHK("frozen_pd", 1'b0, pins.pd_en)
    en = 1'b1;
    wait_ready();
    `CHK("pu_hold", 1'b1, (cyc - c0) >= 32)
    rd_chk(2'h2, 21'h000003);
    summarize();
  end
endmodule
